// [include/jksr_pkg.sv]
// Constants and types shared by the four-stage shift register block
package jksr_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] JKSR_OFS_STATUS = 8'h00;
  localparam logic [7:0] JKSR_OFS_CTRL   = 8'h04;
  localparam logic [7:0] JKSR_OFS_STEP   = 8'h08;
  localparam logic [7:0] JKSR_OFS_COUNT  = 8'h0c;

  // Status field positions
  localparam int JKSR_ST_STAGE_LSB = 0;
  localparam int JKSR_ST_INV_D     = 4;

  // Control field positions
  localparam int JKSR_CT_SOFT_EN   = 0;
  localparam int JKSR_CT_SHIFT     = 1;
  localparam int JKSR_CT_J         = 2;
  localparam int JKSR_CT_K_N       = 3;
  localparam int JKSR_CT_DATA_LSB  = 4;
  localparam int JKSR_CT_WIDTH     = 8;

  // Step field position
  localparam int JKSR_SP_GO        = 0;

  // Widths
  localparam int JKSR_STAGES       = 4;
  localparam int JKSR_CNT_W        = 16;

  // Reset values
  localparam logic [3:0]  JKSR_RST_STAGES = 4'h0;
  localparam logic        JKSR_RST_INV_D  = 1'b1;
  localparam logic [7:0]  JKSR_RST_CTRL   = 8'h00;
  localparam logic [15:0] JKSR_RST_COUNT  = 16'h0000;
  localparam logic        JKSR_RST_PREV   = 1'b1;

  // What enters the first stage on a shift
  typedef enum logic [1:0] {
    JKSR_FIRST_HOLD,
    JKSR_FIRST_TOGGLE,
    JKSR_FIRST_CLEAR,
    JKSR_FIRST_SET
  } jksr_first_e;

endpackage

// [hdl/jksr_core.sv]
// Four register stages with load, shift and inverted last-stage output
`timescale 1ns/100ps
module jksr_core
  import jksr_pkg::*;
(
  // Clock and resets
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       stage_reset_n_i,
  // Controls
  input  wire logic       advance_i,
  input  wire logic       shift_mode_i,
  input  wire logic       first_j_i,
  input  wire logic       first_k_n_i,
  input  wire logic [3:0] par_data_i,
  // Stage outputs
  output logic      [3:0] stages_o,
  output logic            inv_d_o
);

  logic [3:0] nxt_stages;

  function automatic jksr_first_e jksr_decode(input logic j, input logic k_n);
    jksr_decode = JKSR_FIRST_HOLD;
    unique case ({j, k_n})
      2'b01: jksr_decode = JKSR_FIRST_HOLD;
      2'b10: jksr_decode = JKSR_FIRST_TOGGLE;
      2'b00: jksr_decode = JKSR_FIRST_CLEAR;
      2'b11: jksr_decode = JKSR_FIRST_SET;
    endcase
  endfunction

  always_comb begin
    nxt_stages = stages_o;
    if (!shift_mode_i) begin
      nxt_stages = par_data_i;
    end else begin
      nxt_stages[3:1] = stages_o[2:0];
      unique case (jksr_decode(first_j_i, first_k_n_i))
        JKSR_FIRST_HOLD:   nxt_stages[0] = stages_o[0];
        JKSR_FIRST_TOGGLE: nxt_stages[0] = ~stages_o[0];
        JKSR_FIRST_CLEAR:  nxt_stages[0] = 1'b0;
        JKSR_FIRST_SET:    nxt_stages[0] = 1'b1;
      endcase
    end
  end

  // Stage reset is asynchronous and beats every other input
  always_ff @(posedge clk_i or posedge rst_i or negedge stage_reset_n_i) begin
    if (rst_i || !stage_reset_n_i) begin
      stages_o <= JKSR_RST_STAGES;
      inv_d_o  <= JKSR_RST_INV_D;
    end else if (advance_i) begin
      stages_o <= nxt_stages;
      inv_d_o  <= ~nxt_stages[3];
    end
  end

endmodule

// [hdl/jksr_top.sv]
// Top of the four-stage shift register with its bus slave
`timescale 1ns/100ps
module jksr_top
  import jksr_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Shift register pins
  input  wire logic        shift_clk_i,
  input  wire logic        stage_reset_n_i,
  input  wire logic        shift_load_i,
  input  wire logic        first_j_i,
  input  wire logic        first_k_n_i,
  input  wire logic [3:0]  par_data_i,
  // Stage outputs
  output logic             stage_a_out_o,
  output logic             stage_b_out_o,
  output logic             stage_c_out_o,
  output logic             stage_d_out_o,
  output logic             stage_d_inv_o,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        prev_clk_ff;
  logic        step_ff;
  logic [7:0]  ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        bus_req;
  logic        wr_lane0;
  logic        pin_edge;
  logic        advance;
  logic        eff_shift;
  logic        eff_j;
  logic        eff_k_n;
  logic [3:0]  eff_data;
  logic [3:0]  stages_w;
  logic        inv_d_w;

  function automatic logic jksr_hit(input logic [7:0] adr, input logic [7:0] ofs);
    jksr_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // A new request only when no answer is pending, so each access acks once
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock edge and input source

  // Pins are synchronous, so one sample of history suffices
  assign pin_edge = shift_clk_i && !prev_clk_ff;

  // Soft mode steers the stages from the control register instead of pins
  assign eff_shift = ctrl_ff[JKSR_CT_SOFT_EN] ? ctrl_ff[JKSR_CT_SHIFT] : shift_load_i;
  assign eff_j     = ctrl_ff[JKSR_CT_SOFT_EN] ? ctrl_ff[JKSR_CT_J]     : first_j_i;
  assign eff_k_n   = ctrl_ff[JKSR_CT_SOFT_EN] ? ctrl_ff[JKSR_CT_K_N]   : first_k_n_i;
  assign eff_data  = ctrl_ff[JKSR_CT_SOFT_EN]
                   ? ctrl_ff[JKSR_CT_DATA_LSB +: JKSR_STAGES] : par_data_i;

  // Only a rising edge of the selected source moves the stages
  assign advance = ctrl_ff[JKSR_CT_SOFT_EN] ? step_ff : pin_edge;

  // Starts high so a pin already high at release is not an edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_clk_ff <= JKSR_RST_PREV;
    end else begin
      prev_clk_ff <= shift_clk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= JKSR_RST_CTRL;
    end else if (wr_lane0 && jksr_hit(wb_adr_i, JKSR_OFS_CTRL)) begin
      ctrl_ff <= wb_dat_i[JKSR_CT_WIDTH-1:0];
    end
  end

  // Step is a one-cycle pulse; it fires in the same cycle as the write's ack
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_ff <= 1'b0;
    end else begin
      step_ff <= wr_lane0 && jksr_hit(wb_adr_i, JKSR_OFS_STEP) && wb_dat_i[JKSR_SP_GO];
    end
  end

  // Counts advances taken while stage reset is released; a clear and an advance in one cycle leave a count of one
  always_comb begin
    nxt_count = count_ff;
    if (wr_lane0 && jksr_hit(wb_adr_i, JKSR_OFS_COUNT)) begin
      nxt_count = JKSR_RST_COUNT;
    end
    if (advance && stage_reset_n_i) begin
      nxt_count = nxt_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= JKSR_RST_COUNT;
    end else begin
      count_ff <= nxt_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge

  // Unmapped addresses read zero and still ack, so no bus hangs
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (jksr_hit(wb_adr_i, JKSR_OFS_STATUS)) begin
      nxt_rdata[JKSR_ST_STAGE_LSB +: JKSR_STAGES] = stages_w;
      nxt_rdata[JKSR_ST_INV_D]                    = inv_d_w;
    end else if (jksr_hit(wb_adr_i, JKSR_OFS_CTRL)) begin
      nxt_rdata[JKSR_CT_WIDTH-1:0] = ctrl_ff;
    end else if (jksr_hit(wb_adr_i, JKSR_OFS_COUNT)) begin
      nxt_rdata[JKSR_CNT_W-1:0] = count_ff;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= bus_req;
      rdata_ff <= (bus_req && !wb_we_i) ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register stages

  jksr_core u_core (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .stage_reset_n_i (stage_reset_n_i),
    .advance_i       (advance),
    .shift_mode_i    (eff_shift),
    .first_j_i       (eff_j),
    .first_k_n_i     (eff_k_n),
    .par_data_i      (eff_data),
    .stages_o        (stages_w),
    .inv_d_o         (inv_d_w)
  );

  // Core outputs are flip-flops, passed straight out
  assign stage_a_out_o = stages_w[0];
  assign stage_b_out_o = stages_w[1];
  assign stage_c_out_o = stages_w[2];
  assign stage_d_out_o = stages_w[3];
  assign stage_d_inv_o = inv_d_w;

endmodule

// [test/jksr_drv.sv]
// Far-side driver of the shift clock pin
`timescale 1ns/100ps
module jksr_drv (
  // Clock and request
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic step_i,
  // Shift clock, low between steps
  output logic      shift_clk_o
);
  // One cycle high per one-cycle step; a step held high makes it toggle every cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      shift_clk_o <= 1'b0;
    else
      shift_clk_o <= step_i & ~shift_clk_o;
  end
endmodule

// [test/jksr_top_asserts.sv]
// Checker for the stage outputs
`timescale 1ns/100ps
module jksr_top_asserts
  import jksr_pkg::*;
(
  // Clock and resets
  input logic        clk_i,
  input logic        rst_i,
  input logic        stage_reset_n_i,
  // Pins
  input logic        shift_clk_i,
  input logic        shift_load_i,
  input logic        first_j_i,
  input logic        first_k_n_i,
  input logic [3:0]  par_data_i,
  input logic        stage_a_out_o,
  input logic        stage_b_out_o,
  input logic        stage_c_out_o,
  input logic        stage_d_out_o,
  input logic        stage_d_inv_o,
  // Bus, watched only for the soft mode bit
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic        wb_ack_o,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i
);
  logic       prev_ff;
  logic       soft_ff;
  logic       ld;
  logic       sh;
  logic [1:0] jk;
  logic [3:0] q;
  assign q  = {stage_d_out_o, stage_c_out_o, stage_b_out_o, stage_a_out_o};
  assign jk = {first_j_i, first_k_n_i};
  assign ld = shift_clk_i & ~prev_ff & stage_reset_n_i & ~shift_load_i & ~soft_ff;
  assign sh = shift_clk_i & ~prev_ff & stage_reset_n_i & shift_load_i & ~soft_ff;
  // Pins are ignored while software steers the stages
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      soft_ff <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i[7:2] == JKSR_OFS_CTRL[7:2])
      soft_ff <= wb_dat_i[JKSR_CT_SOFT_EN];
  end
  // High in reset: a clock already high then is no edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      prev_ff <= 1'b1;
    else
      prev_ff <= shift_clk_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  a_reset_clears: assert property (!stage_reset_n_i |-> q == 4'h0)
    else $error("stages not clear");
  a_inv_tracks: assert property (stage_d_inv_o == !stage_d_out_o)
    else $error("bad inverse");
  a_load_data: assert property (ld |=> q == $past(par_data_i))
    else $error("bad load");
  a_shift_moves: assert property (sh |=> q[3:1] == $past(q[2:0]))
    else $error("bad shift");
  a_first_keep: assert property (sh && jk == 2'b01 |=> $stable(q[0]))
    else $error("first not kept");
  a_first_toggle: assert property (sh && jk == 2'b10 |=> q[0] != $past(q[0]))
    else $error("first not inverted");
  a_first_forced: assert property (sh && jk[1] == jk[0] |=> q[0] == $past(jk[1]))
    else $error("first not forced");
  a_hold_still: assert property (!(ld || sh || soft_ff) ##1 stage_reset_n_i |-> $stable(q))
    else $error("change without edge");
endmodule
bind jksr_top jksr_top_asserts u_chk (.*);

// [test/jksr_top_tb.sv]
// Bench for the four-stage shift register
`timescale 1ns/100ps
module jksr_top_tb
  import jksr_pkg::*;
;
  // Pins {mode, J, K-bar, data}, then expected stages
  localparam logic [10:0] SEQ [10] = '{11'h0aa, 11'h504, 11'h609, 11'h402, 11'h705,
                                       11'h055, 11'h6fa, 11'h7c5, 11'h53b, 11'h4f6};
  logic        clk_i = 1'b0, rst_i = 1'b1, shift_clk_i, stage_reset_n_i = 1'b1;
  logic        step = 1'b0, shift_load_i = 1'b0, first_j_i = 1'b0, first_k_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic        stage_a_out_o, stage_b_out_o, stage_c_out_o, stage_d_out_o, stage_d_inv_o;
  logic [3:0]  par_data_i = 4'h0, wb_sel_i = 4'hf;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  int          num_errors = 0, num_checks = 0;
  wire  [4:0]  q = {stage_d_inv_o, stage_d_out_o, stage_c_out_o, stage_b_out_o, stage_a_out_o};
  initial forever #50 clk_i = ~clk_i;
  jksr_drv drv (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .shift_clk_o(shift_clk_i));
  jksr_top dut (.*);
  task chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %h, expected %h", $time, got, want);
    end
  endtask
  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Pins stay put until the next step, well past the sampling edge
  task pulse(input logic [6:0] p);
    @(posedge clk_i);
    {shift_load_i, first_j_i, first_k_n_i, par_data_i} <= p;
    step <= 1'b1;
    @(posedge clk_i);
    step <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task wb(input logic w, input logic [3:0] s, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i} <= 2'b11;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= v;
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task t_shift;
    for (int i = 0; i < 10; i++) begin
      pulse(SEQ[i][10:4]);
      chk({27'h0, q}, {27'h0, ~SEQ[i][3], SEQ[i][3:0]});
    end
  endtask
  task t_reset;
    @(posedge clk_i);
    stage_reset_n_i <= 1'b0;
    pulse(7'h0f);
    chk({27'h0, q}, 32'h10);
    @(posedge clk_i);
    stage_reset_n_i <= 1'b1;
  endtask
  // Refused write must leave the count alone
  task t_bus;
    wb(1'b1, 4'hf, JKSR_OFS_COUNT, 32'h5a);
    pulse(7'h06);
    pulse(7'h50);
    wb(1'b1, 4'h0, JKSR_OFS_COUNT, 32'h0);
    wb(1'b0, 4'hf, JKSR_OFS_COUNT, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 4'hf, JKSR_OFS_STATUS, 32'h0);
    chk(rd, 32'h0c);
    @(posedge clk_i);
    {shift_load_i, first_j_i, first_k_n_i, par_data_i} <= 7'h3f;
    repeat (20) @(posedge clk_i);
    wb(1'b0, 4'hf, JKSR_OFS_STATUS, 32'h0);
    chk(rd, 32'h0c);
    wb(1'b0, 4'hf, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Software path; pin edges are refused while it is on
  task t_soft;
    wb(1'b1, 4'hf, JKSR_OFS_CTRL, 32'h91);
    wb(1'b1, 4'hf, JKSR_OFS_STEP, 32'h1);
    wb(1'b0, 4'hf, JKSR_OFS_STATUS, 32'h0);
    chk(rd, 32'h09);
    pulse(7'h0f);
    wb(1'b0, 4'hf, JKSR_OFS_STATUS, 32'h0);
    chk(rd, 32'h09);
    wb(1'b1, 4'hf, JKSR_OFS_CTRL, 32'h07);
    wb(1'b1, 4'hf, JKSR_OFS_STEP, 32'h1);
    wb(1'b0, 4'hf, JKSR_OFS_STATUS, 32'h0);
    chk(rd, 32'h12);
    wb(1'b0, 4'hf, JKSR_OFS_CTRL, 32'h0);
    chk(rd, 32'h07);
    wb(1'b1, 4'hf, JKSR_OFS_CTRL, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_shift();
    t_reset();
    t_bus();
    t_soft();
    summarize();
  end
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
endmodule
